// *** core/sync2.sv ***
// two flip-flop synchroniser for levels and toggles of any width
// assumes each bit is a slow level or a toggle, never a multi-bit word that changes at once
module sync2 #(
	parameter int W = 1
) (
	input wire logic clk, // destination clock
	input wire logic rst, // asynchronous reset, active high
	input wire logic [W-1:0] d, // level from the other domain
	output logic [W-1:0] q // synchronised level
);

	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= '0;
			q_r <= '0;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end

	assign q = q_r;

endmodule

// *** core/temp_sensor_register_alarm_core.sv ***
// register file, conversion pacing and alarm flag of a digital temperature sensor
// assumes a byte-level link front end on link_clk that has already decoded bus framing,
// and a converter on mclk that answers each conv_start pulse with one conv_done pulse

// What this block does
// - 8-bit pointer; two low bits writable, bits 2 to 7 read zero.
// - pointer bits select temperature, setup, lower or upper for later accesses.
// - temperature result ignores writes; lower and upper store and return written values, setup only its writable fields.
// - sixteen-bit words move most significant byte first, then least significant.
// - setup bits 0-4 and 13 read zero, bit 14 reads one, all read-only.
// - with level select clear, flag idles one, drops after enough high readings.
// - asserted flag holds until enough consecutive readings fall to or below lower limit.
// - level select set inverts the alarm flag.
// - in comparator operation the alarm pin mirrors the alarm flag.
// - rate field gives 4 s, 1 s, 250 ms, 125 ms; resets to 250 ms.
// - temperature result changes only when a conversion completes.
// - conversion starts at reset; standby between scheduled conversions.
// - registers reached only over the serial link; converter writes results.
module temp_sensor_register_alarm_core import tsense_pkg::*; #(
	parameter logic [31:0] CYC_4S = PERIOD_4S_CYC, // cycles per 4 s period
	parameter logic [31:0] CYC_1S = PERIOD_1S_CYC, // cycles per 1 s period
	parameter logic [31:0] CYC_250MS = PERIOD_250MS_CYC, // cycles per 250 ms period
	parameter logic [31:0] CYC_125MS = PERIOD_125MS_CYC // cycles per 125 ms period
) (
	input wire logic mclk, // system clock, 125 MHz
	input wire logic rst, // asynchronous reset, active high
	input wire logic link_clk, // link clock
	input wire logic lk_start, // pulse: new transaction begins
	input wire logic lk_dir_rd, // with lk_start: 1 read, 0 write
	input wire logic lk_wr_valid, // pulse: a written byte is present
	input wire logic [7:0] lk_wr_byte, // written byte
	input wire logic lk_rd_req, // pulse: controller takes the next read byte
	output logic [7:0] lk_rd_byte, // read byte
	output logic lk_rd_valid, // pulse: lk_rd_byte updated
	output logic lk_busy, // request still crossing, hold off
	output logic [7:0] lk_pointer, // pointer register contents
	output logic conv_start, // pulse: start one conversion
	input wire logic conv_done, // pulse: conversion finished
	input wire logic [15:0] conv_result, // result valid with conv_done
	output logic alert_out, // alarm pin driven level
	output logic alert_oe_n // alarm pin enable, low while driving
);

	typedef enum logic [1:0] {ST_START, ST_CONV, ST_STANDBY} conv_state_t;

	// ---------------- link domain ----------------
	logic [1:0] lk_ptr_r, lk_ptr_nxt;
	logic [1:0] lk_idx_r, lk_idx_nxt;
	logic [7:0] lk_msb_r, lk_msb_nxt;
	bus_cmd_t lk_cmd_r, lk_cmd_nxt;
	logic lk_req_r, lk_req_nxt;
	logic lk_ack_d_r, lk_ack_d_nxt;
	logic [15:0] lk_word_r, lk_word_nxt;
	logic [7:0] lk_rdbyte_r, lk_rdbyte_nxt;
	logic lk_rdlsb_r, lk_rdlsb_nxt;
	logic lk_rdv_r, lk_rdv_nxt;
	logic lk_busy_r, lk_busy_nxt;
	logic lk_ack_s;
	logic lk_pending;

	// ---------------- system domain ----------------
	logic req_s;
	logic req_seen_r, req_seen_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic [15:0] temp_r, temp_nxt;
	logic [15:0] lower_r, lower_nxt;
	logic [15:0] upper_r, upper_nxt;
	logic [1:0] rate_r, rate_nxt;
	logic shut_r, shut_nxt;
	logic evt_r, evt_nxt;
	logic lvl_r, lvl_nxt;
	logic [1:0] fault_r, fault_nxt;
	logic shot_r, shot_nxt;
	logic active_r, active_nxt;
	logic [1:0] hi_cnt_r, hi_cnt_nxt;
	logic [1:0] lo_cnt_r, lo_cnt_nxt;
	logic flag_r, flag_nxt;
	logic oe_n_r, oe_n_nxt;
	logic conv_start_r, conv_start_nxt;
	conv_state_t state_r, state_nxt;
	logic [31:0] tmr_r, tmr_nxt;
	logic tmr_exp;
	setup_word_t setup_view;
	logic alert_out_r;

	// toggle handshake: request into mclk, acknowledge back into link_clk
	sync2 #(.W(1)) u_req_sync (
		.clk(mclk),
		.rst(rst),
		.d(lk_req_r),
		.q(req_s)
	);

	sync2 #(.W(1)) u_ack_sync (
		.clk(link_clk),
		.rst(rst),
		.d(req_seen_r),
		.q(lk_ack_s)
	);

	assign lk_pending = lk_req_r != lk_ack_s;

	// link byte handling; lk_cmd_r stays still while a request is pending
	always_comb begin
		lk_ptr_nxt = lk_ptr_r;
		lk_idx_nxt = lk_idx_r;
		lk_msb_nxt = lk_msb_r;
		lk_cmd_nxt = lk_cmd_r;
		lk_req_nxt = lk_req_r;
		lk_ack_d_nxt = lk_ack_s;
		lk_word_nxt = lk_word_r;
		lk_rdbyte_nxt = lk_rdbyte_r;
		lk_rdlsb_nxt = lk_rdlsb_r;
		lk_rdv_nxt = 1'b0;
		// rdata_r is frozen in mclk until the next request, so it is safe to take here
		if (lk_ack_s != lk_ack_d_r && lk_cmd_r.rd) begin
			lk_word_nxt = rdata_r;
		end
		if (lk_start) begin
			lk_idx_nxt = IDX_PTR;
			lk_rdlsb_nxt = 1'b0;
			if (lk_dir_rd && !lk_pending) begin
				lk_cmd_nxt = '{rd: 1'b1, sel: lk_ptr_r, data: 16'h0000};
				lk_req_nxt = ~lk_req_r;
			end
		end else if (lk_wr_valid) begin
			if (lk_idx_r == IDX_PTR) begin
				lk_ptr_nxt = lk_wr_byte[1:0];
				lk_idx_nxt = IDX_MSB;
			end else if (lk_idx_r == IDX_MSB) begin
				lk_msb_nxt = lk_wr_byte;
				lk_idx_nxt = IDX_LSB;
			end else if (lk_idx_r == IDX_LSB) begin
				lk_idx_nxt = IDX_DONE;
				if (!lk_pending) begin
					lk_cmd_nxt = '{rd: 1'b0, sel: lk_ptr_r, data: {lk_msb_r, lk_wr_byte}};
					lk_req_nxt = ~lk_req_r;
				end
			end
		end else if (lk_rd_req) begin
			lk_rdbyte_nxt = lk_rdlsb_r ? lk_word_r[7:0] : lk_word_r[15:8];
			lk_rdlsb_nxt = ~lk_rdlsb_r;
			lk_rdv_nxt = 1'b1;
		end
		lk_busy_nxt = lk_req_nxt != lk_ack_s;
	end

	// link domain registers
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			lk_ptr_r <= SEL_TEMP;
			lk_idx_r <= IDX_PTR;
			lk_msb_r <= 8'h00;
			lk_cmd_r <= CMD_RST;
			lk_req_r <= 1'b0;
			lk_ack_d_r <= 1'b0;
			lk_word_r <= 16'h0000;
			lk_rdbyte_r <= 8'h00;
			lk_rdlsb_r <= 1'b0;
			lk_rdv_r <= 1'b0;
			lk_busy_r <= 1'b0;
		end else begin
			lk_ptr_r <= lk_ptr_nxt;
			lk_idx_r <= lk_idx_nxt;
			lk_msb_r <= lk_msb_nxt;
			lk_cmd_r <= lk_cmd_nxt;
			lk_req_r <= lk_req_nxt;
			lk_ack_d_r <= lk_ack_d_nxt;
			lk_word_r <= lk_word_nxt;
			lk_rdbyte_r <= lk_rdbyte_nxt;
			lk_rdlsb_r <= lk_rdlsb_nxt;
			lk_rdv_r <= lk_rdv_nxt;
			lk_busy_r <= lk_busy_nxt;
		end
	end

	assign lk_rd_byte = lk_rdbyte_r;
	assign lk_rd_valid = lk_rdv_r;
	assign lk_busy = lk_busy_r;
	assign lk_pointer = {PTR_UPPER_ZERO, lk_ptr_r};

	// setup word as read back; reserved bits are fixed constants
	always_comb begin
		setup_view.oneshot = shot_r;
		setup_view.rsv14 = SETUP_RSV14;
		setup_view.rsv13 = SETUP_RSV13;
		setup_view.fault_count_field = fault_r;
		setup_view.alarm_level_select = lvl_r;
		setup_view.event_mode_select = evt_r;
		setup_view.shutdown_select = shut_r;
		setup_view.sample_rate_field = rate_r;
		setup_view.alarm_flag = flag_r;
		setup_view.rsv_low = SETUP_RSV_LOW;
	end

	assign tmr_exp = tmr_r == 32'h0000_0000;

	// requests, conversion pacing and alarm evaluation in the system domain
	always_comb begin
		req_seen_nxt = req_seen_r;
		rdata_nxt = rdata_r;
		temp_nxt = temp_r;
		lower_nxt = lower_r;
		upper_nxt = upper_r;
		rate_nxt = rate_r;
		shut_nxt = shut_r;
		evt_nxt = evt_r;
		lvl_nxt = lvl_r;
		fault_nxt = fault_r;
		shot_nxt = shot_r;
		active_nxt = active_r;
		hi_cnt_nxt = hi_cnt_r;
		lo_cnt_nxt = lo_cnt_r;
		state_nxt = state_r;
		// reload only on expiry, so a new rate waits for the running period
		if (tmr_exp) begin
			case (rate_r)
				RATE_4S: tmr_nxt = CYC_4S - 32'h0000_0001;
				RATE_1S: tmr_nxt = CYC_1S - 32'h0000_0001;
				RATE_250MS: tmr_nxt = CYC_250MS - 32'h0000_0001;
				default: tmr_nxt = CYC_125MS - 32'h0000_0001;
			endcase
		end else begin
			tmr_nxt = tmr_r - 32'h0000_0001;
		end
		case (state_r)
			ST_START: state_nxt = ST_CONV;
			ST_CONV: begin
				if (conv_done) begin
					state_nxt = ST_STANDBY;
					temp_nxt = conv_result;
					shot_nxt = 1'b0;
					// consecutive-reading filter, threshold count is field value plus one
					if (!active_r) begin
						lo_cnt_nxt = 2'h0;
						if ($signed(conv_result) >= $signed(upper_r)) begin
							hi_cnt_nxt = hi_cnt_r + 2'h1;
							if (hi_cnt_r == fault_r) begin
								active_nxt = 1'b1;
								hi_cnt_nxt = 2'h0;
							end
						end else begin
							hi_cnt_nxt = 2'h0;
						end
					end else begin
						hi_cnt_nxt = 2'h0;
						if ($signed(conv_result) <= $signed(lower_r)) begin
							lo_cnt_nxt = lo_cnt_r + 2'h1;
							if (lo_cnt_r == fault_r) begin
								active_nxt = 1'b0;
								lo_cnt_nxt = 2'h0;
							end
						end else begin
							lo_cnt_nxt = 2'h0;
						end
					end
				end
			end
			ST_STANDBY: begin
				if (tmr_exp && !shut_r) begin
					state_nxt = ST_START;
				end
			end
			default: state_nxt = ST_START;
		endcase
		// a new toggle from the link: serve one read or one write
		if (req_s != req_seen_r) begin
			req_seen_nxt = req_s;
			if (lk_cmd_r.rd) begin
				if (lk_cmd_r.sel == SEL_TEMP) begin
					rdata_nxt = temp_r;
				end else if (lk_cmd_r.sel == SEL_SETUP) begin
					rdata_nxt = setup_view;
				end else if (lk_cmd_r.sel == SEL_LOWER) begin
					rdata_nxt = lower_r;
				end else begin
					rdata_nxt = upper_r;
				end
			end else if (lk_cmd_r.sel == SEL_SETUP) begin
				// reserved and flag bits, bit 4 among them, are not stored
				rate_nxt = lk_cmd_r.data[7:6];
				shut_nxt = lk_cmd_r.data[8];
				evt_nxt = lk_cmd_r.data[9];
				lvl_nxt = lk_cmd_r.data[10];
				fault_nxt = lk_cmd_r.data[12:11];
				// one-shot only runs from shutdown while no conversion is underway
				if (lk_cmd_r.data[15] && shut_r && state_r == ST_STANDBY) begin
					shot_nxt = 1'b1;
					state_nxt = ST_START;
				end
			end else if (lk_cmd_r.sel == SEL_LOWER) begin
				lower_nxt = lk_cmd_r.data;
			end else if (lk_cmd_r.sel == SEL_UPPER) begin
				upper_nxt = lk_cmd_r.data;
			end
			// writes to the temperature result fall through untouched
		end
		flag_nxt = lvl_nxt ? active_nxt : ~active_nxt;
		oe_n_nxt = flag_nxt;
		// taken from the present state, so the reset state itself gives the first start pulse
		conv_start_nxt = state_r == ST_START;
	end

	// system domain registers; constant reset values only
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			req_seen_r <= 1'b0;
			rdata_r <= 16'h0000;
			temp_r <= TEMP_RST;
			lower_r <= LOWER_RST;
			upper_r <= UPPER_RST;
			rate_r <= RATE_RST;
			shut_r <= 1'b0;
			evt_r <= 1'b0;
			lvl_r <= 1'b0;
			fault_r <= 2'h0;
			shot_r <= 1'b0;
			active_r <= 1'b0;
			hi_cnt_r <= 2'h0;
			lo_cnt_r <= 2'h0;
			flag_r <= 1'b1;
			oe_n_r <= 1'b1;
			conv_start_r <= 1'b0;
			state_r <= ST_START;
			tmr_r <= CYC_250MS - 32'h0000_0001;
			alert_out_r <= 1'b0;
		end else begin
			req_seen_r <= req_seen_nxt;
			rdata_r <= rdata_nxt;
			temp_r <= temp_nxt;
			lower_r <= lower_nxt;
			upper_r <= upper_nxt;
			rate_r <= rate_nxt;
			shut_r <= shut_nxt;
			evt_r <= evt_nxt;
			lvl_r <= lvl_nxt;
			fault_r <= fault_nxt;
			shot_r <= shot_nxt;
			active_r <= active_nxt;
			hi_cnt_r <= hi_cnt_nxt;
			lo_cnt_r <= lo_cnt_nxt;
			flag_r <= flag_nxt;
			oe_n_r <= oe_n_nxt;
			conv_start_r <= conv_start_nxt;
			state_r <= state_nxt;
			tmr_r <= tmr_nxt;
			alert_out_r <= 1'b0; // open drain: only ever pulls low
		end
	end

	assign conv_start = conv_start_r;
	assign alert_out = alert_out_r;
	assign alert_oe_n = oe_n_r;

endmodule

// *** core/tsense_pkg.sv ***
// constants, register map and carrier types shared by the temperature sensor core
// assumes a 125 MHz system clock and a byte-wide link front end on its own clock
package tsense_pkg;

	// register select codes held in the two writable pointer bits
	localparam logic [1:0] SEL_TEMP = 2'h0;
	localparam logic [1:0] SEL_SETUP = 2'h1;
	localparam logic [1:0] SEL_LOWER = 2'h2;
	localparam logic [1:0] SEL_UPPER = 2'h3;
	localparam logic [5:0] PTR_UPPER_ZERO = 6'h00;

	// byte positions inside a write transaction
	localparam logic [1:0] IDX_PTR = 2'h0;
	localparam logic [1:0] IDX_MSB = 2'h1;
	localparam logic [1:0] IDX_LSB = 2'h2;
	localparam logic [1:0] IDX_DONE = 2'h3;

	// reset values
	localparam logic [15:0] TEMP_RST = 16'h0000;
	localparam logic [15:0] LOWER_RST = 16'h04B0;
	localparam logic [15:0] UPPER_RST = 16'h0500;
	localparam logic [1:0] RATE_RST = 2'h2;
	localparam logic [4:0] SETUP_RSV_LOW = 5'h00;
	localparam logic SETUP_RSV13 = 1'b0;
	localparam logic SETUP_RSV14 = 1'b1;

	// rate field encodings
	localparam logic [1:0] RATE_4S = 2'h0;
	localparam logic [1:0] RATE_1S = 2'h1;
	localparam logic [1:0] RATE_250MS = 2'h2;
	localparam logic [1:0] RATE_125MS = 2'h3;

	// conversion periods in their own unit, and the clock in kHz
	localparam int unsigned PERIOD_4S_MS = 4000;
	localparam int unsigned PERIOD_1S_MS = 1000;
	localparam int unsigned PERIOD_250MS_MS = 250;
	localparam int unsigned PERIOD_125MS_MS = 125;
	localparam int unsigned MCLK_KHZ = 125000;
	localparam logic [31:0] PERIOD_4S_CYC = 32'(PERIOD_4S_MS * MCLK_KHZ);
	localparam logic [31:0] PERIOD_1S_CYC = 32'(PERIOD_1S_MS * MCLK_KHZ);
	localparam logic [31:0] PERIOD_250MS_CYC = 32'(PERIOD_250MS_MS * MCLK_KHZ);
	localparam logic [31:0] PERIOD_125MS_CYC = 32'(PERIOD_125MS_MS * MCLK_KHZ);

	// setup word, laid out exactly as software sees it
	typedef struct packed {
		logic oneshot;
		logic rsv14;
		logic rsv13;
		logic [1:0] fault_count_field;
		logic alarm_level_select;
		logic event_mode_select;
		logic shutdown_select;
		logic [1:0] sample_rate_field;
		logic alarm_flag;
		logic [4:0] rsv_low;
	} setup_word_t;

	// one request crossing from the link domain to the system domain
	typedef struct packed {
		logic rd;
		logic [1:0] sel;
		logic [15:0] data;
	} bus_cmd_t;

	localparam bus_cmd_t CMD_RST = '{rd: 1'b0, sel: SEL_TEMP, data: 16'h0000};

endpackage

// *** verif/alarm_core_properties.sv ***
// concurrent checks on the sensor core link and conversion ports
// assumes it is bound to the core and sees only its ports
module alarm_core_props (
	input wire logic mclk, // system clock
	input wire logic rst, // reset, active high
	input wire logic link_clk, // link clock
	input wire logic lk_start, // transaction start
	input wire logic lk_dir_rd, // read direction
	input wire logic lk_wr_valid, // written byte strobe
	input wire logic lk_rd_req, // read byte request
	input wire logic [7:0] lk_rd_byte, // read byte
	input wire logic lk_rd_valid, // read byte strobe
	input wire logic lk_busy, // crossing in progress
	input wire logic [7:0] lk_pointer, // pointer contents
	input wire logic conv_start, // conversion start
	input wire logic alert_out // alarm pin level
);
	// link domain
	a_ptr_high_zero: assert property (@(posedge link_clk) disable iff (rst)
		lk_pointer[7:2] == 6'h00) else $error("pointer upper bits set");
	a_ptr_on_write: assert property (@(posedge link_clk) disable iff (rst)
		!$stable(lk_pointer) |-> $past(lk_wr_valid)) else $error("pointer moved without write");
	a_read_goes_busy: assert property (@(posedge link_clk) disable iff (rst)
		lk_start && lk_dir_rd && !lk_busy |=> lk_busy) else $error("read start not taken");
	// the crossing must come back; a lost ack would hang the controller
	a_busy_bounded: assert property (@(posedge link_clk) disable iff (rst)
		$rose(lk_busy) |-> ##[1:40] !lk_busy) else $error("busy never released");
	a_byte_on_req: assert property (@(posedge link_clk) disable iff (rst)
		lk_rd_req && !lk_start |=> lk_rd_valid) else $error("no byte after request");
	a_valid_has_req: assert property (@(posedge link_clk) disable iff (rst)
		lk_rd_valid |-> $past(lk_rd_req)) else $error("byte strobe without request");
	a_byte_holds: assert property (@(posedge link_clk) disable iff (rst)
		!lk_rd_valid |-> $stable(lk_rd_byte)) else $error("read byte changed unasked");
	// system domain
	a_start_spaced: assert property (@(posedge mclk) disable iff (rst)
		conv_start |=> !conv_start [*8]) else $error("conversion starts too close");
	a_pin_open_drain: assert property (@(posedge mclk) disable iff (rst)
		alert_out == 1'b0) else $error("alarm pin driven high");
endmodule

bind temp_sensor_register_alarm_core alarm_core_props alarm_core_props_i (.mclk(mclk),
	.rst(rst), .link_clk(link_clk), .lk_start(lk_start), .lk_dir_rd(lk_dir_rd),
	.lk_wr_valid(lk_wr_valid), .lk_rd_req(lk_rd_req), .lk_rd_byte(lk_rd_byte),
	.lk_rd_valid(lk_rd_valid), .lk_busy(lk_busy), .lk_pointer(lk_pointer),
	.conv_start(conv_start), .alert_out(alert_out));

// *** verif/link_host_model.sv ***
// bus controller stand-in on the core's byte-level link ports
// assumes a free link clock; changes outputs on its falling edge
module link_host_model import tsense_pkg::*; (
	input wire logic link_clk, // link clock
	input wire logic [7:0] lk_rd_byte, // read byte from the core
	input wire logic lk_rd_valid, // read byte strobe
	input wire logic lk_busy, // core still crossing a request
	output logic lk_start, // transaction start pulse
	output logic lk_dir_rd, // read when set
	output logic lk_wr_valid, // written byte strobe
	output logic [7:0] lk_wr_byte, // written byte
	output logic lk_rd_req, // read byte request
	output logic hung // a bounded wait ran out
);
	timeunit 1ns;
	timeprecision 1ps;
	// quiet until the bench asks for a transfer
	initial begin
		lk_start = 1'b0;
		lk_dir_rd = 1'b0;
		lk_wr_valid = 1'b0;
		lk_wr_byte = 8'h00;
		lk_rd_req = 1'b0;
		hung = 1'b0;
	end
	// one transaction start pulse
	task automatic open_xfer(input logic rd);
		@(negedge link_clk);
		lk_start = 1'b1;
		lk_dir_rd = rd;
		@(negedge link_clk);
		lk_start = 1'b0;
	endtask
	// data flips after the strobe so a stale byte is never mistaken for a new one
	task automatic put(input logic [7:0] b);
		@(negedge link_clk);
		lk_wr_valid = 1'b1;
		lk_wr_byte = b;
		@(negedge link_clk);
		lk_wr_valid = 1'b0;
		lk_wr_byte = ~b;
	endtask
	// bounded wait for the crossing to finish
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (2) @(negedge link_clk);
		while (lk_busy && n < 40) begin
			@(negedge link_clk);
			n++;
		end
		hung = lk_busy;
	endtask
	// byte arrives one cycle after the request
	task automatic get(output logic [7:0] b);
		@(negedge link_clk);
		lk_rd_req = 1'b1;
		@(negedge link_clk);
		lk_rd_req = 1'b0;
		hung = !lk_rd_valid;
		b = lk_rd_byte;
	endtask
	task automatic write_word(input logic [1:0] sel, input logic [15:0] v);
		if (sel == SEL_SETUP)
			v[4] = 1'b0;
		open_xfer(1'b0);
		put({PTR_UPPER_ZERO, sel});
		put(v[15:8]);
		put(v[7:0]);
		wait_idle();
	endtask
	task automatic write_ptr(input logic [7:0] p);
		open_xfer(1'b0);
		put(p);
		repeat (2) @(negedge link_clk);
	endtask
	task automatic read_cur(output logic [15:0] v);
		open_xfer(1'b1);
		wait_idle();
		get(v[15:8]);
		get(v[7:0]);
	endtask
	task automatic read_word(input logic [1:0] sel, output logic [15:0] v);
		write_ptr({PTR_UPPER_ZERO, sel});
		read_cur(v);
	endtask
endmodule

// *** verif/test_temp_sensor_register_alarm_core.sv ***
// self-checking bench for the sensor register and alarm core
// assumes the host model on the link and the property checker bound to the core
`define CHK(got, exp, what) \
	begin \
		n_tests++; \
		if ((got) !== (exp)) begin \
			err_count++; \
			$display("MISMATCH t=%0t %s", $time, what); \
		end \
	end
module test_temp_sensor_register_alarm_core import tsense_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] PER [4] = '{32'h190, 32'h64, 32'h19, 32'hC};
	logic mclk, rst, link_clk, conv_done, conv_start, host_hung, alert_out, alert_oe_n;
	logic lk_start, lk_dir_rd, lk_wr_valid, lk_rd_req, lk_rd_valid, lk_busy;
	logic [7:0] lk_wr_byte, lk_rd_byte, lk_pointer;
	logic [15:0] conv_result, cur_temp, w;
	logic [2:0] conv_wait;
	int err_count, n_tests, n_conv, since_start, last_gap;
	temp_sensor_register_alarm_core #(.CYC_4S(PER[0]), .CYC_1S(PER[1]), .CYC_250MS(PER[2]),
		.CYC_125MS(PER[3])) temp_sensor_register_alarm_core_i (.mclk(mclk), .rst(rst),
		.link_clk(link_clk), .lk_start(lk_start), .lk_dir_rd(lk_dir_rd),
		.lk_wr_valid(lk_wr_valid), .lk_wr_byte(lk_wr_byte), .lk_rd_req(lk_rd_req),
		.lk_rd_byte(lk_rd_byte), .lk_rd_valid(lk_rd_valid), .lk_busy(lk_busy),
		.lk_pointer(lk_pointer), .conv_start(conv_start), .conv_done(conv_done),
		.conv_result(conv_result), .alert_out(alert_out), .alert_oe_n(alert_oe_n));
	link_host_model link_host_model_i (.link_clk(link_clk), .lk_rd_byte(lk_rd_byte),
		.lk_rd_valid(lk_rd_valid), .lk_busy(lk_busy), .lk_start(lk_start),
		.lk_dir_rd(lk_dir_rd), .lk_wr_valid(lk_wr_valid), .lk_wr_byte(lk_wr_byte),
		.lk_rd_req(lk_rd_req), .hung(host_hung));
	// system clock, and a link clock of its own period and phase
	always #4 mclk = ~mclk;
	initial begin
		link_clk = 1'b0;
		#7;
		forever #15 link_clk = ~link_clk;
	end
	// converter stand-in: result four cycles after each start, junk otherwise
	always @(negedge mclk) begin
		since_start++;
		if (conv_start) begin
			last_gap = since_start;
			since_start = 0;
		end
		conv_done = (conv_wait == 3'h1);
		conv_result = (conv_wait == 3'h1) ? cur_temp : ~cur_temp;
		// counted as it is driven, so a counted result always carries the current cur_temp
		n_conv += int'(conv_done);
		conv_wait = conv_start ? 3'h4 : ((conv_wait == 3'h0) ? 3'h0 : conv_wait - 3'h1);
	end
	// a link wait that ran out ends the run
	always @(posedge host_hung) begin
		err_count++;
		tally_and_finish();
	end
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wait_conv(input int k);
		int lim;
		lim = n_conv + k;
		for (int i = 0; i < 3000 && n_conv < lim; i++)
			@(negedge mclk);
		if (n_conv < lim) begin
			err_count++;
			tally_and_finish();
		end
		repeat (3) @(negedge mclk);
	endtask
	task automatic t_reset();
		`CHK(lk_pointer, 8'h00, "pointer reset");
		`CHK(n_conv > 0, 1'b1, "no conversion after reset");
		link_host_model_i.read_word(SEL_SETUP, w);
		`CHK(w, 16'h40A0, "setup reset");
		link_host_model_i.read_word(SEL_LOWER, w);
		`CHK(w, LOWER_RST, "lower reset");
		link_host_model_i.read_word(SEL_UPPER, w);
		`CHK(w, UPPER_RST, "upper reset");
		$display("t_reset done");
	endtask
	task automatic t_regs();
		link_host_model_i.write_word(SEL_LOWER, 16'h0080);
		link_host_model_i.write_word(SEL_UPPER, 16'h0100);
		link_host_model_i.write_word(SEL_TEMP, 16'h7FFF);
		link_host_model_i.read_word(SEL_LOWER, w);
		`CHK(w, 16'h0080, "lower readback");
		link_host_model_i.read_word(SEL_UPPER, w);
		`CHK(w, 16'h0100, "upper readback");
		link_host_model_i.read_word(SEL_TEMP, w);
		`CHK(w, cur_temp, "result took a write");
		link_host_model_i.write_word(SEL_SETUP, 16'h7EEF);
		link_host_model_i.read_word(SEL_SETUP, w);
		`CHK(w, 16'h5EC0, "setup readback");
		`CHK(alert_oe_n, 1'b0, "inverted idle pin");
		$display("t_regs done");
	endtask
	// two consecutive readings needed each way, level select clear
	task automatic t_alarm();
		link_host_model_i.write_word(SEL_SETUP, 16'h0880);
		cur_temp = 16'h0200;
		wait_conv(1);
		`CHK(alert_oe_n, 1'b1, "alarm after one reading");
		wait_conv(1);
		`CHK(alert_oe_n, 1'b0, "no alarm after two");
		link_host_model_i.read_word(SEL_SETUP, w);
		`CHK(w, 16'h4880, "flag bit");
		cur_temp = 16'h00C0;
		wait_conv(2);
		`CHK(alert_oe_n, 1'b0, "alarm not held");
		cur_temp = 16'h0040;
		wait_conv(2);
		`CHK(alert_oe_n, 1'b1, "alarm not released");
		$display("t_alarm done");
	endtask
	task automatic t_rate();
		for (int i = 0; i < 4; i++) begin
			link_host_model_i.write_word(SEL_SETUP, {8'h00, 2'(i), 6'h00});
			wait_conv(3);
			`CHK(last_gap == PER[i] || last_gap == PER[i] + 1, 1'b1, "period");
		end
		$display("t_rate done");
	endtask
	task automatic t_ptr();
		link_host_model_i.write_ptr(8'hFF);
		`CHK(lk_pointer, 8'h03, "pointer read-only bits");
		link_host_model_i.read_cur(w);
		`CHK(w, 16'h0100, "read at pointer");
		link_host_model_i.read_cur(w);
		`CHK(w, 16'h0100, "repeat read at pointer");
		link_host_model_i.write_ptr(8'h00);
		link_host_model_i.read_cur(w);
		`CHK(w, cur_temp, "last result");
		$display("t_ptr done");
	endtask
	// shutdown stops the pacing; a one-shot then runs exactly one conversion
	task automatic t_sleep();
		int c;
		link_host_model_i.write_word(SEL_SETUP, 16'h0180);
		repeat (20) @(negedge mclk);
		c = n_conv;
		repeat (100) @(negedge mclk);
		`CHK(n_conv, c, "converted in shutdown");
		link_host_model_i.write_word(SEL_SETUP, 16'h8180);
		repeat (100) @(negedge mclk);
		`CHK(n_conv, c + 1, "one-shot count");
		link_host_model_i.write_word(SEL_SETUP, 16'h0080);
		$display("t_sleep done");
	endtask
	// reset, then the scenarios in turn
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		conv_done = 1'b0;
		conv_wait = 3'h0;
		conv_result = 16'h0000;
		cur_temp = 16'h0000;
		repeat (12) @(negedge mclk);
		rst = 1'b0;
		repeat (4) @(negedge link_clk);
		t_reset();
		t_regs();
		t_alarm();
		t_rate();
		t_sleep();
		t_ptr();
		tally_and_finish();
	end
endmodule
